// ==== logic/fpec_pkg.sv ====
// Package: register map, field positions and timing for the flash protect/event block
`default_nettype none
package fpec_pkg;
	localparam logic [7:0] PROT_OFFSET = 8'hFA;
	localparam logic [7:0] EVT_OFFSET = 8'hFB;
	localparam logic [7:0] PROT_RESET = 8'hFF;
	localparam logic [7:0] EVT_RESET = 8'h00;
	localparam int DONE_IE_BIT = 7;
	localparam int ERR_IE_BIT = 6;
	localparam int DONE_FLAG_BIT = 5;
	localparam int TMO_BIT = 3;
	localparam int WR_VIOL_BIT = 2;
	localparam int PE_VIOL_BIT = 1;
	localparam int ME_VIOL_BIT = 0;
	localparam int BLOCK_ADDR_LSB = 14;
	localparam int ROW_TIMEOUT_FCLKS = 2432;
	localparam int ROW_PROG_ACTIVE_BIT = 2;

	typedef enum logic [1:0]
	{
		FPEC_OP_WRITE = 2'b00,
		FPEC_OP_PAGE_ERASE = 2'b01,
		FPEC_OP_MASS_ERASE = 2'b10,
		FPEC_OP_ROW_PROG = 2'b11
	} fpec_op_t;

	typedef struct packed
	{
		logic valid;
		fpec_op_t op;
		logic info_page;
		logic [16:0] addr;
	} fpec_req_t;

	typedef struct packed
	{
		logic sel;
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fpec_io_t;
endpackage : fpec_pkg
`default_nettype wire

// ==== logic/fpec_row_timer.sv ====
// Row-program watchdog counting flash controller clock ticks
`default_nettype none
module fpec_row_timer #(
	parameter int LIMIT = fpec_pkg::ROW_TIMEOUT_FCLKS
)(
	input wire logic clk,
	input wire logic rstn,
	input wire logic active,
	input wire logic fclk_tick,
	output logic expired
);
	localparam int CW = $clog2(LIMIT + 1);

	if (LIMIT < 1)
	begin : g_bad_limit
		$error("fpec_row_timer: LIMIT must be at least 1");
	end

	typedef struct packed
	{
		logic [CW-1:0] cnt;
		logic expired;
	} fpec_tmr_state_t;

	fpec_tmr_state_t st_ff;
	fpec_tmr_state_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.expired = 1'b0;
		if (!active)
			nxt_st.cnt = '0;
		else if (fclk_tick)
		begin
			// One-cycle pulse on the tick that reaches the limit
			if (st_ff.cnt == CW'(LIMIT - 1))
				nxt_st.expired = 1'b1;
			if (st_ff.cnt != CW'(LIMIT))
				nxt_st.cnt = st_ff.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign expired = st_ff.expired;
endmodule : fpec_row_timer
`default_nettype wire

// ==== logic/fpec_ctrl.sv ====
// Flash block protection, violation checking, row-program timeout and event flags
`default_nettype none
module fpec_ctrl #(
	parameter int BLOCKS = 8,
	parameter int ROW_TIMEOUT = fpec_pkg::ROW_TIMEOUT_FCLKS
)(
	input wire logic clk,
	input wire logic rstn,
	input wire fpec_pkg::fpec_io_t io,
	input wire logic unlocked,
	input wire fpec_pkg::fpec_req_t req,
	input wire logic op_done,
	input wire logic row_prog_active,
	input wire logic fclk_tick,
	output logic [7:0] rdata,
	output logic grant,
	output logic refuse,
	output logic row_prog_abort,
	output logic irq
);
	// Elaboration checks on geometry and on the register layout that the decode assumes
	if (BLOCKS != 8 && BLOCKS != 4)
	begin : g_bad_blocks
		$error("fpec_ctrl: BLOCKS must be 4 or 8");
	end

	if (ROW_TIMEOUT < 1)
	begin : g_bad_timeout
		$error("fpec_ctrl: ROW_TIMEOUT must be at least 1");
	end

	if (fpec_pkg::PROT_OFFSET == fpec_pkg::EVT_OFFSET)
	begin : g_bad_offsets
		$error("fpec_ctrl: the two register offsets must differ");
	end

	// A locked write and reset both rely on the all-ones pattern
	if (fpec_pkg::PROT_RESET != 8'hFF)
	begin : g_bad_prot_reset
		$error("fpec_ctrl: mask reset value must protect every block");
	end

	// Error flags must fill the low nibble that a read clears, one bit each
	if (((1 << fpec_pkg::TMO_BIT) | (1 << fpec_pkg::WR_VIOL_BIT)
		| (1 << fpec_pkg::PE_VIOL_BIT) | (1 << fpec_pkg::ME_VIOL_BIT)) != 15)
	begin : g_bad_err_bits
		$error("fpec_ctrl: error flag bits must cover 3..0 once each");
	end

	if (fpec_pkg::DONE_FLAG_BIT < 4 || fpec_pkg::DONE_FLAG_BIT > 7
		|| fpec_pkg::DONE_IE_BIT < 4 || fpec_pkg::DONE_IE_BIT > 7
		|| fpec_pkg::ERR_IE_BIT < 4 || fpec_pkg::ERR_IE_BIT > 7)
	begin : g_bad_upper_range
		$error("fpec_ctrl: enable and done bits must lie in 7..4");
	end

	if (fpec_pkg::DONE_IE_BIT == fpec_pkg::ERR_IE_BIT
		|| fpec_pkg::DONE_IE_BIT == fpec_pkg::DONE_FLAG_BIT
		|| fpec_pkg::ERR_IE_BIT == fpec_pkg::DONE_FLAG_BIT)
	begin : g_bad_upper_bits
		$error("fpec_ctrl: enable and done bits must be distinct");
	end

	// Block index is the three offset bits above the 16 KB boundary
	if (fpec_pkg::BLOCK_ADDR_LSB + 3 != $bits(fpec_pkg::fpec_req_t) - 4)
	begin : g_bad_addr_split
		$error("fpec_ctrl: block index must be the top three offset bits");
	end

	typedef struct packed
	{
		logic [7:0] mask;
		logic done_ie;
		logic err_ie;
		logic done_flag;
		logic [3:0] err_flags;
		logic [7:0] rdata;
		logic grant;
		logic refuse;
		logic abort;
		logic irq;
	} fpec_ctrl_state_t;

	fpec_ctrl_state_t st_ff;
	fpec_ctrl_state_t nxt_st;
	logic tmo_expired;
	logic [2:0] blk_idx;
	logic blk_guarded;
	logic any_guard;
	logic [7:0] live_mask;
	logic viol_wr;
	logic viol_pe;
	logic viol_me;
	logic [3:0] err_set;
	logic [7:0] evt_view;
	logic io_prot_wr;
	logic io_prot_rd;
	logic io_evt_wr;
	logic io_evt_rd;
	logic op_wr;
	logic op_pe;
	logic op_me;
	logic op_rp;
	logic viol_any;
	logic allow;
	logic guard_block_0;
	logic guard_block_1;
	logic guard_block_2;
	logic guard_block_3;
	logic guard_block_4;
	logic guard_block_5;
	logic guard_block_6;
	logic guard_block_7;
	logic [7:0] guard_vec;

	fpec_row_timer #(
		.LIMIT(ROW_TIMEOUT)
	) u_row_timer (
		.clk(clk),
		.rstn(rstn),
		.active(row_prog_active),
		.fclk_tick(fclk_tick),
		.expired(tmo_expired)
	);

	// Unused upper bits on the small part never guard anything but still read back
	if (BLOCKS == 8)
	begin : g_full_map
		assign live_mask = st_ff.mask;
	end
	else
	begin : g_half_map
		assign live_mask = {4'h0, st_ff.mask[3:0]};
	end

	// One guard per 16 KB block, lowest offsets on bit 0
	assign guard_block_0 = live_mask[0];
	assign guard_block_1 = live_mask[1];
	assign guard_block_2 = live_mask[2];
	assign guard_block_3 = live_mask[3];
	assign guard_block_4 = live_mask[4];
	assign guard_block_5 = live_mask[5];
	assign guard_block_6 = live_mask[6];
	assign guard_block_7 = live_mask[7];
	assign guard_vec = {guard_block_7, guard_block_6, guard_block_5, guard_block_4,
		guard_block_3, guard_block_2, guard_block_1, guard_block_0};

	assign blk_idx = req.addr[fpec_pkg::BLOCK_ADDR_LSB +: 3];
	assign blk_guarded = guard_vec[blk_idx] && !req.info_page;
	assign any_guard = |guard_vec;

	// Register decode; other offsets are ignored
	always_comb
	begin
		io_prot_wr = 1'b0;
		io_prot_rd = 1'b0;
		io_evt_wr = 1'b0;
		io_evt_rd = 1'b0;
		if (io.sel && io.addr == fpec_pkg::PROT_OFFSET)
		begin
			io_prot_wr = io.wr;
			io_prot_rd = io.rd;
		end
		else if (io.sel && io.addr == fpec_pkg::EVT_OFFSET)
		begin
			io_evt_wr = io.wr;
			io_evt_rd = io.rd;
		end
	end

	// Operation decode, one strobe per kind of request
	always_comb
	begin
		op_wr = 1'b0;
		op_pe = 1'b0;
		op_me = 1'b0;
		op_rp = 1'b0;
		if (req.valid)
		begin
			case (req.op)
				fpec_pkg::FPEC_OP_WRITE: op_wr = 1'b1;
				fpec_pkg::FPEC_OP_PAGE_ERASE: op_pe = 1'b1;
				fpec_pkg::FPEC_OP_MASS_ERASE: op_me = 1'b1;
				fpec_pkg::FPEC_OP_ROW_PROG: op_rp = 1'b1;
				default: op_wr = 1'b0;
			endcase
		end
	end

	// A row program writes flash, so a guarded target is a write violation
	assign viol_wr = (op_wr || op_rp) && blk_guarded;
	assign viol_pe = op_pe && blk_guarded;
	assign viol_me = op_me && any_guard;
	assign viol_any = viol_wr || viol_pe || viol_me;
	assign allow = req.valid && !viol_any;

	always_comb
	begin
		err_set = 4'h0;
		err_set[fpec_pkg::TMO_BIT] = tmo_expired;
		err_set[fpec_pkg::WR_VIOL_BIT] = viol_wr;
		err_set[fpec_pkg::PE_VIOL_BIT] = viol_pe;
		err_set[fpec_pkg::ME_VIOL_BIT] = viol_me;
	end

	always_comb
	begin
		evt_view = 8'h00;
		evt_view[fpec_pkg::DONE_IE_BIT] = st_ff.done_ie;
		evt_view[fpec_pkg::ERR_IE_BIT] = st_ff.err_ie;
		evt_view[fpec_pkg::DONE_FLAG_BIT] = st_ff.done_flag;
		evt_view[3:0] = st_ff.err_flags;
		evt_view[4] = 1'b0;
	end

	always_comb
	begin
		nxt_st = st_ff;
		// Verdict for the request taken this cycle
		nxt_st.grant = allow;
		nxt_st.refuse = viol_any;
		nxt_st.abort = tmo_expired;

		// Register write side; a locked write traps a runaway store as full protection
		if (io_prot_wr)
		begin
			if (unlocked)
				nxt_st.mask = io.wdata;
			else
				nxt_st.mask = fpec_pkg::PROT_RESET;
		end
		else if (io_evt_wr)
		begin
			nxt_st.done_ie = io.wdata[fpec_pkg::DONE_IE_BIT];
			nxt_st.err_ie = io.wdata[fpec_pkg::ERR_IE_BIT];
		end

		// Read data is registered; read of event register clears its flags
		nxt_st.rdata = 8'h00;
		if (io_prot_rd)
		begin
			nxt_st.rdata = st_ff.mask;
		end
		else if (io_evt_rd)
		begin
			nxt_st.rdata = evt_view;
			nxt_st.done_flag = 1'b0;
			nxt_st.err_flags = 4'h0;
		end

		// New events win over a same-cycle read clear
		if (op_done)
			nxt_st.done_flag = 1'b1;
		nxt_st.err_flags = nxt_st.err_flags | err_set;

		// Level request from registered flags and enables
		nxt_st.irq = (nxt_st.done_ie && nxt_st.done_flag)
			|| (nxt_st.err_ie && (|nxt_st.err_flags));
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st_ff <= '0;
			st_ff.mask <= fpec_pkg::PROT_RESET;
			st_ff.done_ie <= fpec_pkg::EVT_RESET[fpec_pkg::DONE_IE_BIT];
			st_ff.err_ie <= fpec_pkg::EVT_RESET[fpec_pkg::ERR_IE_BIT];
			st_ff.done_flag <= fpec_pkg::EVT_RESET[fpec_pkg::DONE_FLAG_BIT];
			st_ff.err_flags <= fpec_pkg::EVT_RESET[3:0];
		end
		else
			st_ff <= nxt_st;
	end

	assign rdata = st_ff.rdata;
	assign grant = st_ff.grant;
	assign refuse = st_ff.refuse;
	assign row_prog_abort = st_ff.abort;
	assign irq = st_ff.irq;
endmodule : fpec_ctrl
`default_nettype wire

// ==== verif/fpec_props.sv ====
// Port assertions for the flash protect and event block
`default_nettype none
module fpec_props #(
	parameter int BLOCKS = 8,
	parameter int ROW_TIMEOUT = fpec_pkg::ROW_TIMEOUT_FCLKS
)(
	input wire logic clk,
	input wire logic rstn,
	input wire fpec_pkg::fpec_io_t io,
	input wire logic unlocked,
	input wire fpec_pkg::fpec_req_t req,
	input wire logic op_done,
	input wire logic row_prog_active,
	input wire logic fclk_tick,
	input wire logic [7:0] rdata,
	input wire logic grant,
	input wire logic refuse,
	input wire logic row_prog_abort,
	input wire logic irq
);
	wire logic me = req.valid && req.op == fpec_pkg::FPEC_OP_MASS_ERASE;
	wire logic pw = io.sel && io.wr && io.addr == fpec_pkg::PROT_OFFSET;
	wire logic er = io.sel && io.rd && io.addr == fpec_pkg::EVT_OFFSET;
	wire logic ev = !req.valid && !op_done && !row_prog_active;
	wire logic hit = row_prog_active && fclk_tick;
	logic [15:0] tick_ff;
	// Restarts when the program bit drops, as a new row would
	always_ff @(posedge clk)
		tick_ff <= (!rstn || !row_prog_active) ? 16'h0000 : tick_ff + 16'(fclk_tick);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	one_verdict_a: assert property (req.valid |=> grant ^ refuse)
		else $error("bad verdict");
	no_stray_a: assert property (!req.valid |=> !grant && !refuse)
		else $error("stray verdict");
	info_open_a: assert property (req.valid && req.info_page && !me |=> grant)
		else $error("info page blocked");
	locked_force_a: assert property (pw && !unlocked ##1 me && !pw |=> refuse)
		else $error("mask not forced");
	mass_open_a: assert property (pw && unlocked && io.wdata == 8'h00 ##1 me && !pw
		|=> grant) else $error("mass erase blocked");
	evt_clear_a: assert property (er && ev ##1 er
		|=> rdata[5] == 1'b0 && rdata[3:0] == 4'h0) else $error("flags kept");
	irq_drop_a: assert property (er && ev |=> !irq)
		else $error("irq held");
	abort_time_a: assert property (hit && tick_ff == 16'(ROW_TIMEOUT - 1)
		|=> ##1 row_prog_abort) else $error("no abort");
	abort_only_a: assert property (row_prog_abort |-> $past(hit, 2))
		else $error("stray abort");
endmodule : fpec_props
bind fpec_ctrl fpec_props #(.BLOCKS(BLOCKS), .ROW_TIMEOUT(ROW_TIMEOUT)) u_props (.clk, .rstn,
	.io, .unlocked, .req, .op_done, .row_prog_active, .fclk_tick, .rdata, .grant, .refuse,
	.row_prog_abort, .irq);
`default_nettype wire

// ==== verif/fpec_ctrl_tb_top.sv ====
// Self-checking bench for the flash protect and event block
`default_nettype none
module fpec_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] PA = fpec_pkg::PROT_OFFSET;
	localparam logic [7:0] EA = fpec_pkg::EVT_OFFSET;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	fpec_pkg::fpec_io_t io = '0;
	fpec_pkg::fpec_req_t req = '0;
	logic unlocked = 1'b0;
	logic op_done = 1'b0;
	logic row_prog_active = 1'b0;
	logic fclk_tick = 1'b0;
	logic [7:0] rdata;
	logic grant, refuse, row_prog_abort, irq;
	logic [7:0] q[$];
	logic rd_pend = 1'b0;
	int bad_count = 0;
	int cmp_count = 0;
	fpec_ctrl #(.BLOCKS(8), .ROW_TIMEOUT(8)) dut (.clk, .rstn, .io, .unlocked, .req, .op_done,
		.row_prog_active, .fclk_tick, .rdata, .grant, .refuse, .row_prog_abort, .irq);
	initial forever #5 clk = ~clk;
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask : chk
	task cyc(input fpec_pkg::fpec_io_t i, input fpec_pkg::fpec_req_t r);
		@(posedge clk);
		io <= i;
		req <= r;
	endtask : cyc
	task rd(input logic [7:0] a, input logic [7:0] e);
		cyc('{1'b1, 1'b0, 1'b1, a, 8'h00}, '0);
		q.push_back(e);
	endtask : rd
	task wr(input logic [7:0] a, input logic [7:0] d);
		cyc('{1'b1, 1'b1, 1'b0, a, d}, '0);
	endtask : wr
	task op(input fpec_pkg::fpec_op_t o, input logic i, input logic [2:0] b, input logic g);
		cyc('0, '{1'b1, o, i, {b, 14'($urandom)}});
		q.push_back({6'h00, g, !g});
	endtask : op
	task idle2_irq(input logic e);
		cyc('0, '0);
		cyc('0, '0);
		@(negedge clk);
		chk({7'h00, irq}, {7'h00, e});
	endtask : idle2_irq
	task results;
		chk(8'(q.size()), 8'h00);
		$display("mismatches %0d comparisons %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results
	// Results land one cycle late, so notes are matched on the falling edge
	always @(negedge clk)
	begin
		if (rd_pend)
			chk(rdata, q.pop_front());
		if ((grant | refuse) === 1'b1)
			chk({6'h00, grant, refuse}, q.pop_front());
		rd_pend = io.sel && io.rd;
	end
	initial
	begin
		#50000;
		bad_count++;
		results();
	end
	initial
	begin
		void'($urandom(74));
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		rd(PA, 8'hFF);
		wr(PA, 8'h00);
		op(fpec_pkg::FPEC_OP_MASS_ERASE, 1'b0, 3'h0, 1'b0);
		rd(EA, 8'h01);
		rd(EA, 8'h00);
		rd(PA, 8'hFF);
		unlocked <= 1'b1;
		for (int n = 0; n < 8; n++)
		begin
			wr(PA, 8'h01 << n);
			rd(PA, 8'h01 << n);
			op(fpec_pkg::FPEC_OP_WRITE, 1'b0, 3'(n), 1'b0);
			op(fpec_pkg::FPEC_OP_WRITE, 1'b0, 3'(n + 1), 1'b1);
			op(fpec_pkg::FPEC_OP_PAGE_ERASE, 1'b0, 3'(n), 1'b0);
			op(fpec_pkg::FPEC_OP_ROW_PROG, 1'b1, 3'(n), 1'b1);
			rd(EA, 8'h06);
		end
		wr(PA, 8'h00);
		op(fpec_pkg::FPEC_OP_MASS_ERASE, 1'b0, 3'h0, 1'b1);
		wr(EA, 8'h80);
		op_done <= 1'b1;
		cyc('0, '0);
		op_done <= 1'b0;
		idle2_irq(1'b1);
		rd(EA, 8'hA0);
		idle2_irq(1'b0);
		wr(EA, 8'h40);
		wr(PA, 8'h01);
		op(fpec_pkg::FPEC_OP_WRITE, 1'b0, 3'h0, 1'b0);
		idle2_irq(1'b1);
		wr(EA, 8'h00);
		idle2_irq(1'b0);
		rd(EA, 8'h04);
		row_prog_active <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			repeat ($urandom_range(3)) cyc('0, '0);
			fclk_tick <= 1'b1;
			cyc('0, '0);
			fclk_tick <= 1'b0;
		end
		// Expiry is registered in the timer and again in the abort flop
		@(posedge clk);
		@(negedge clk);
		chk({7'h00, row_prog_abort}, 8'h01);
		rd(EA, 8'h08);
		row_prog_active <= 1'b0;
		cyc('0, '0);
		cyc('0, '0);
		results();
	end
endmodule : fpec_ctrl_tb_top
`default_nettype wire
